// ===== hdl/hvif_defines.svh
// Constants of the high-voltage indirect register interface
`ifndef HVIF_DEFINES_SVH
`define HVIF_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define HVIF_ADDR_CMD     32'hFFFF_0804
`define HVIF_ADDR_DAT     32'hFFFF_080C

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define HVIF_CODE_RD_CFG0 8'h00
`define HVIF_CODE_RD_CFG1 8'h01
`define HVIF_CODE_RD_STAT 8'h02
`define HVIF_CODE_RD_MON  8'h03
`define HVIF_CODE_WR_CFG0 8'h08
`define HVIF_CODE_WR_CFG1 8'h09
`define HVIF_CODE_WR_BIT  3

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define HVIF_BUSY_BIT     0
`define HVIF_RXOK_BIT     1
`define HVIF_TXOK_BIT     2
`define HVIF_TAG_MSB      11
`define HVIF_TAG_LSB      8
`define HVIF_BYTE_MSB     7
`define HVIF_DAT_RST      12'h000
`define HVIF_BYTE_RST     8'h00
`define HVIF_WORD_ZERO    32'h0000_0000
`define HVIF_BITCNT_TOP   3'h7
`define HVIF_BITCNT_END   3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HVIF_SYS_NS       25
`define HVIF_LINK_NS      48
`define HVIF_SCK_KHZ      2560
`define HVIF_LAT_NS       10000
`define HVIF_LAT_CYC      (`HVIF_LAT_NS / `HVIF_SYS_NS)
`define HVIF_SCK_HALF     ((1000000 / (2 * `HVIF_SCK_KHZ)) / `HVIF_LINK_NS)

`endif

// ===== hdl/hvif_pkg.sv
// Types shared by the high-voltage indirect register interface
`default_nettype none

package hvif_pkg;

   typedef enum logic [2:0] {
      LnkIdle,
      LnkCmd,
      LnkWdat,
      LnkAck1,
      LnkRdat,
      LnkAck2,
      LnkDone
   } hvif_lstate_type;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] data;
   } hvif_req_type;

   typedef struct packed {
      logic       txOk;
      logic       rxOk;
      logic [7:0] data;
   } hvif_res_type;

endpackage

`default_nettype wire

// ===== hdl/hvif_sync.sv
// Two-flop synchroniser, one chain per bit
`default_nettype none

module hvif_sync #(
   parameter int Width = 1
) (
   // Destination clock
   input  wire logic             clk,
   // Bits from another domain
   input  wire logic [Width-1:0] din,
   output logic      [Width-1:0] dout
);

   genvar i;
   generate
      for (i = 0; i < Width; i++) begin : g_bit
         // Each chain owns its flops so no bit of dout has two writers
         logic stage1_ff;
         logic stage2_ff;
         always_ff @(posedge clk) begin
            stage1_ff <= din[i];
            stage2_ff <= stage1_ff;
         end
         assign dout[i] = stage2_ff;
      end
   endgenerate

endmodule

`default_nettype wire

// ===== hdl/hvif_tick.sv
// Half-bit tick generator for the serial clock, link domain
`include "hvif_defines.svh"
`default_nettype none

module hvif_tick
   import hvif_pkg::*;
(
   // Link clock and reset
   input  wire logic clk,
   input  wire logic rstN,
   // Control and tick
   input  wire logic run,
   output logic      tick
);

   localparam logic [2:0] Last = 3'(`HVIF_SCK_HALF - 1);

   logic [2:0] cnt_ff;
   logic [2:0] nxt_cnt;
   logic       tick_ff;
   logic       nxt_tick;

   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_tick = 1'b0;
      if (!run) begin
         nxt_cnt = 3'h0;
      end else if (cnt_ff == Last) begin
         nxt_cnt  = 3'h0;
         nxt_tick = 1'b1;
      end else begin
         nxt_cnt = cnt_ff + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstN) begin
         cnt_ff  <= 3'h0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;

endmodule

`default_nettype wire

// ===== hdl/hvif_top.sv
// High-voltage indirect register interface: registers and serial link
// ----------------------------------------------------------------
// How it works
// - A command byte reads or writes one of four 8-bit indirect registers.
// - Indirect registers have no address of their own in the map.
// - Traffic uses one clock line and one data line at about 2.56 MHz.
// - A write and its data reach the far register within 10 us.
// - Read data lands in the data register within 10 us of the command.
// - Codes 0x00 and 0x01 read the first and second configuration registers.
// - Codes 0x02 and 0x03 read the status and monitor registers.
// - Codes 0x08 and 0x09 copy the data byte to the two config registers.
// - The data register holds the byte to send and takes the byte read back.
// - Command bit 0 reads 1 while busy, and bits 1 and 2 are then invalid.
// - Bit 0 reads 0 when done, and bits 1 and 2 then hold the results.
// - Bit 2 reads 1 when the far die acknowledged the command, else 0.
// - Bit 1 reads 1 when the far die completed a read, else 0.
// - Data register is 12 bits: 11-8 the code, read-only, and 7-0 the byte.
// ----------------------------------------------------------------
`include "hvif_defines.svh"
`default_nettype none

module hvif_top
   import hvif_pkg::*;
(
   // System clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // Register port
   input  wire logic [31:0] regAddr,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   input  wire logic [31:0] regWdata,
   output logic      [31:0] regRdata,
   output logic             regRdValid,
   // Serial link to the high-voltage die
   input  wire logic        linkClk,
   output logic             sckOut,
   output logic             sdaOut,
   output logic             sdaOeN,
   input  wire logic        sdaIn
);

   localparam int MaxLat = `HVIF_LAT_CYC;

   // ----------------------------------------------------------------
   // System side: decode
   // ----------------------------------------------------------------
   logic              hitCmd;
   logic              hitDat;
   logic              cmdValid;
   logic              accept;
   logic              doneSync;
   logic              doneEdge;
   logic              busy_ff;
   logic              txOk_ff;
   logic              rxOk_ff;
   logic              reqTgl_ff;
   logic              doneSeen_ff;
   logic [11:0]       dat_ff;
   hvif_req_type      req_ff;
   logic [31:0]       rdata_ff;
   logic              rdValid_ff;
   logic              nxt_busy;
   logic              nxt_txOk;
   logic              nxt_rxOk;
   logic              nxt_reqTgl;
   logic              nxt_doneSeen;
   logic [11:0]       nxt_dat;
   hvif_req_type      nxt_req;
   logic [31:0]       nxt_rdata;
   logic              nxt_rdValid;
   logic [7:0]        statByte;
   hvif_res_type      res_ff;

   assign hitCmd = (regAddr == `HVIF_ADDR_CMD);
   assign hitDat = (regAddr == `HVIF_ADDR_DAT);

   always_comb begin
      case (regWdata[7:0])
         `HVIF_CODE_RD_CFG0,
         `HVIF_CODE_RD_CFG1,
         `HVIF_CODE_RD_STAT,
         `HVIF_CODE_RD_MON,
         `HVIF_CODE_WR_CFG0,
         `HVIF_CODE_WR_CFG1: cmdValid = 1'b1;
         default:            cmdValid = 1'b0;
      endcase
   end

   // A command written while busy is dropped rather than corrupting
   // the frame in flight
   assign accept   = regWrEn && hitCmd && cmdValid && !busy_ff;
   assign doneEdge = (doneSync != doneSeen_ff);

   // ----------------------------------------------------------------
   // System side: command, status and data registers
   // ----------------------------------------------------------------
   always_comb begin
      nxt_busy     = busy_ff;
      nxt_txOk     = txOk_ff;
      nxt_rxOk     = rxOk_ff;
      nxt_reqTgl   = reqTgl_ff;
      nxt_doneSeen = doneSync;
      nxt_dat      = dat_ff;
      nxt_req      = req_ff;
      if (regWrEn && hitDat) begin
         nxt_dat[`HVIF_BYTE_MSB:0] = regWdata[`HVIF_BYTE_MSB:0];
      end
      if (accept) begin
         nxt_busy   = 1'b1;
         nxt_txOk   = 1'b0;
         nxt_rxOk   = 1'b0;
         nxt_reqTgl = !reqTgl_ff;
         nxt_req    = {regWdata[7:0], dat_ff[`HVIF_BYTE_MSB:0]};
         nxt_dat[`HVIF_TAG_MSB:`HVIF_TAG_LSB] = regWdata[3:0];
      end
      // Completion of a read overrides a software data write in the same cycle
      if (doneEdge) begin
         nxt_busy = 1'b0;
         nxt_txOk = res_ff.txOk;
         nxt_rxOk = res_ff.rxOk;
         nxt_dat[`HVIF_TAG_MSB:`HVIF_TAG_LSB] = req_ff.code[3:0];
         if (!req_ff.code[`HVIF_CODE_WR_BIT]) begin
            nxt_dat[`HVIF_BYTE_MSB:0] = res_ff.data;
         end
      end
   end

   always_comb begin
      statByte                 = `HVIF_BYTE_RST;
      statByte[`HVIF_BUSY_BIT] = busy_ff;
      statByte[`HVIF_RXOK_BIT] = rxOk_ff;
      statByte[`HVIF_TXOK_BIT] = txOk_ff;
      nxt_rdValid = regRdEn;
      nxt_rdata   = `HVIF_WORD_ZERO;
      if (regRdEn && hitCmd) begin
         nxt_rdata[7:0] = statByte;
      end else if (regRdEn && hitDat) begin
         nxt_rdata[11:0] = dat_ff;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         busy_ff     <= 1'b0;
         txOk_ff     <= 1'b0;
         rxOk_ff     <= 1'b0;
         reqTgl_ff   <= 1'b0;
         doneSeen_ff <= 1'b0;
         dat_ff      <= `HVIF_DAT_RST;
         req_ff      <= '0;
         rdata_ff    <= `HVIF_WORD_ZERO;
         rdValid_ff  <= 1'b0;
      end else begin
         busy_ff     <= nxt_busy;
         txOk_ff     <= nxt_txOk;
         rxOk_ff     <= nxt_rxOk;
         reqTgl_ff   <= nxt_reqTgl;
         doneSeen_ff <= nxt_doneSeen;
         dat_ff      <= nxt_dat;
         req_ff      <= nxt_req;
         rdata_ff    <= nxt_rdata;
         rdValid_ff  <= nxt_rdValid;
      end
   end

   assign regRdata   = rdata_ff;
   assign regRdValid = rdValid_ff;

   // ----------------------------------------------------------------
   // Domain crossings
   // ----------------------------------------------------------------
   logic              lRstN;
   logic              reqSync;
   logic              sdaSync;
   logic              doneTgl_ff;

   hvif_sync #(.Width(3)) u_toLink (
      .clk  (linkClk),
      .din  ({nrst, reqTgl_ff, sdaIn}),
      .dout ({lRstN, reqSync, sdaSync})
   );

   hvif_sync #(.Width(1)) u_toSys (
      .clk  (clk_sys),
      .din  (doneTgl_ff),
      .dout (doneSync)
   );

   // ----------------------------------------------------------------
   // Link side: serial frame engine
   // ----------------------------------------------------------------
   hvif_lstate_type   lState_ff;
   hvif_lstate_type   nxt_lState;
   logic [2:0]        bitCnt_ff;
   logic [2:0]        nxt_bitCnt;
   logic [7:0]        shift_ff;
   logic [7:0]        nxt_shift;
   logic              sck_ff;
   logic              nxt_sck;
   logic              sdaOut_ff;
   logic              nxt_sdaOut;
   logic              sdaOeN_ff;
   logic              nxt_sdaOeN;
   logic              reqSeen_ff;
   logic              nxt_reqSeen;
   logic              nxt_doneTgl;
   hvif_req_type      lReq_ff;
   hvif_req_type      nxt_lReq;
   hvif_res_type      nxt_res;
   logic              tick;
   logic              driving;

   hvif_tick u_tick (
      .clk  (linkClk),
      .rstN (lRstN),
      .run  (lState_ff != LnkIdle),
      .tick (tick)
   );

   assign driving = (lState_ff == LnkCmd) || (lState_ff == LnkWdat);

   always_comb begin
      nxt_lState  = lState_ff;
      nxt_bitCnt  = bitCnt_ff;
      nxt_shift   = shift_ff;
      nxt_sck     = sck_ff;
      nxt_sdaOut  = sdaOut_ff;
      nxt_sdaOeN  = sdaOeN_ff;
      nxt_reqSeen = reqSeen_ff;
      nxt_doneTgl = doneTgl_ff;
      nxt_lReq    = lReq_ff;
      nxt_res     = res_ff;
      case (lState_ff)
         LnkIdle: begin
            nxt_sck    = 1'b1;
            nxt_sdaOeN = 1'b1;
            // The request word is held still by the busy flag
            if (reqSync != reqSeen_ff) begin
               nxt_reqSeen = reqSync;
               nxt_lReq    = req_ff;
               nxt_shift   = req_ff.code;
               nxt_bitCnt  = `HVIF_BITCNT_TOP;
               nxt_res     = '0;
               nxt_lState  = LnkCmd;
            end
         end
         LnkDone: begin
            if (tick) begin
               nxt_doneTgl = !doneTgl_ff;
               nxt_lState  = LnkIdle;
            end
         end
         default: begin
            if (tick && sck_ff) begin
               // Falling edge: present the next bit or release the line
               nxt_sck    = 1'b0;
               nxt_sdaOut = shift_ff[7];
               nxt_sdaOeN = !driving;
            end else if (tick) begin
               // Rising edge: both ends sample here
               nxt_sck = 1'b1;
               case (lState_ff)
                  LnkCmd, LnkWdat: begin
                     nxt_shift  = {shift_ff[6:0], 1'b0};
                     nxt_bitCnt = bitCnt_ff - 3'h1;
                     if (bitCnt_ff != `HVIF_BITCNT_END) begin
                        nxt_lState = lState_ff;
                     end else if (lState_ff == LnkCmd &&
                                  lReq_ff.code[`HVIF_CODE_WR_BIT]) begin
                        nxt_shift  = lReq_ff.data;
                        nxt_bitCnt = `HVIF_BITCNT_TOP;
                        nxt_lState = LnkWdat;
                     end else begin
                        nxt_lState = LnkAck1;
                     end
                  end
                  LnkAck1: begin
                     nxt_res.txOk = !sdaSync;
                     nxt_bitCnt   = `HVIF_BITCNT_TOP;
                     nxt_lState   = lReq_ff.code[`HVIF_CODE_WR_BIT] ?
                                    LnkDone : LnkRdat;
                  end
                  LnkRdat: begin
                     nxt_shift  = {shift_ff[6:0], sdaSync};
                     nxt_bitCnt = bitCnt_ff - 3'h1;
                     if (bitCnt_ff == `HVIF_BITCNT_END) begin
                        nxt_lState = LnkAck2;
                     end
                  end
                  LnkAck2: begin
                     nxt_res.rxOk = !sdaSync;
                     nxt_res.data = shift_ff;
                     nxt_lState   = LnkDone;
                  end
                  default: nxt_lState = LnkIdle;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge linkClk) begin
      if (!lRstN) begin
         lState_ff  <= LnkIdle;
         bitCnt_ff  <= `HVIF_BITCNT_TOP;
         shift_ff   <= `HVIF_BYTE_RST;
         sck_ff     <= 1'b1;
         sdaOut_ff  <= 1'b1;
         sdaOeN_ff  <= 1'b1;
         reqSeen_ff <= 1'b0;
         doneTgl_ff <= 1'b0;
         lReq_ff    <= '0;
         res_ff     <= '0;
      end else begin
         lState_ff  <= nxt_lState;
         bitCnt_ff  <= nxt_bitCnt;
         shift_ff   <= nxt_shift;
         sck_ff     <= nxt_sck;
         sdaOut_ff  <= nxt_sdaOut;
         sdaOeN_ff  <= nxt_sdaOeN;
         reqSeen_ff <= nxt_reqSeen;
         doneTgl_ff <= nxt_doneTgl;
         lReq_ff    <= nxt_lReq;
         res_ff     <= nxt_res;
      end
   end

   assign sckOut = sck_ff;
   assign sdaOut = sdaOut_ff;
   assign sdaOeN = sdaOeN_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_badWrite;
      regWrEn && hitCmd && !cmdValid && !busy_ff;
   endsequence

   sequence s_finish;
      $fell(busy_ff);
   endsequence

   property p_acceptBusy;
      @(posedge clk_sys) disable iff (!nrst)
      accept |=> busy_ff && (reqTgl_ff != $past(reqTgl_ff));
   endproperty
   a_acceptBusy: assert property (p_acceptBusy)
      else $error("accepted command did not raise busy");

   property p_ignoreBad;
      @(posedge clk_sys) disable iff (!nrst)
      s_badWrite |=> !busy_ff && $stable(reqTgl_ff);
   endproperty
   a_ignoreBad: assert property (p_ignoreBad)
      else $error("undefined code started a transfer");

   property p_latency;
      @(posedge clk_sys) disable iff (!nrst)
      $rose(busy_ff) |-> ##[1:MaxLat] !busy_ff;
   endproperty
   a_latency: assert property (p_latency)
      else $error("command took longer than the latency limit");

   property p_tagCode;
      @(posedge clk_sys) disable iff (!nrst)
      s_finish |-> dat_ff[`HVIF_TAG_MSB:`HVIF_TAG_LSB] == req_ff.code[3:0];
   endproperty
   a_tagCode: assert property (p_tagCode)
      else $error("data tag does not match the command");

   property p_readCopy;
      @(posedge clk_sys) disable iff (!nrst)
      s_finish and !req_ff.code[`HVIF_CODE_WR_BIT]
         |-> dat_ff[`HVIF_BYTE_MSB:0] == res_ff.data;
   endproperty
   a_readCopy: assert property (p_readCopy)
      else $error("read data not copied to data register");

   property p_status;
      @(posedge clk_sys) disable iff (!nrst)
      s_finish |-> txOk_ff == res_ff.txOk && rxOk_ff == res_ff.rxOk;
   endproperty
   a_status: assert property (p_status)
      else $error("completion flags do not match the frame");

   property p_unmapped;
      @(posedge clk_sys) disable iff (!nrst)
      regRdEn && !hitCmd && !hitDat |=> regRdValid && regRdata == 0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned data");

   property p_idleLines;
      @(posedge linkClk) disable iff (!lRstN)
      lState_ff == LnkIdle |=> sck_ff && sdaOeN_ff;
   endproperty
   a_idleLines: assert property (p_idleLines)
      else $error("link not released while idle");

   property p_sckHalf;
      @(posedge linkClk) disable iff (!lRstN)
      $fell(sck_ff) |-> (!sck_ff)[*4] ##1 sck_ff;
   endproperty
   a_sckHalf: assert property (p_sckHalf)
      else $error("serial clock low phase has the wrong length");

   property p_msbFirst;
      @(posedge linkClk) disable iff (!lRstN)
      $fell(sck_ff) && lState_ff == LnkCmd && bitCnt_ff == 3'h7
         |-> sdaOut_ff == lReq_ff.code[7] && !sdaOeN_ff;
   endproperty
   a_msbFirst: assert property (p_msbFirst)
      else $error("command not sent MSB first");

endmodule

`default_nettype wire

// ===== test/hv_indirect_register_interface_test.sv
// Self-checking bench of the high-voltage indirect register interface
`include "hvif_defines.svh"
`default_nettype none

module hv_indirect_register_interface_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        linkClk = 1'b0;
   logic        nrst = 1'b0;
   logic [31:0] regAddr = '0;
   logic [31:0] regWdata = '0;
   logic        regWrEn = 1'b0;
   logic        regRdEn = 1'b0;
   logic        noAck = 1'b0;
   logic [31:0] regRdata;
   logic [31:0] rd;
   logic        regRdValid;
   logic        sckOut;
   logic        sdaOut;
   logic        sdaOeN;
   logic        sdaIn;
   logic [7:0]  cfgFirst;
   logic [7:0]  cfgSecond;
   int          nErrors = 0;
   int          numChecks = 0;

   always #12.5 clk_sys = ~clk_sys;
   always #24 linkClk = ~linkClk;

   hvif_top i_hvif_top (.clk_sys, .nrst, .regAddr, .regWrEn, .regRdEn,
      .regWdata, .regRdata, .regRdValid, .linkClk, .sckOut, .sdaOut,
      .sdaOeN, .sdaIn);
   hvif_far_model #(.StatVal(8'hA5), .MonVal(8'h3C)) i_hvif_far_model (
      .linkClk, .sckOut, .sdaOut, .sdaOeN, .sdaIn, .noAck, .cfgFirst,
      .cfgSecond);

   // ----------------------------------------------------------------
   // Bus cycles and checking
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (nErrors == 0 && numChecks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWrEn <= 1'b1;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
   endtask

   task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk_sys);
      regRdEn <= 1'b0;
      #1;
      check({31'h0, regRdValid}, 32'h1);
      d = regRdata;
   endtask

   // Poll the busy bit; the bound, about 15 us, is half again the latency limit
   task automatic wait_idle(input realtime t0);
      logic [31:0] s;
      for (int i = 0; i < 300; i++) begin
         reg_rd(`HVIF_ADDR_CMD, s);
         if (s[0] === 1'b0) begin
            check({31'h0, ($realtime - t0) <= 10000.0}, 32'h1);
            return;
         end
      end
      nErrors++;
      give_verdict();
   endtask

   task automatic t_reset();
      reg_rd(`HVIF_ADDR_CMD, rd);
      check(rd, 32'h0);
      reg_rd(`HVIF_ADDR_DAT, rd);
      check(rd, 32'h0);
      reg_rd(32'hFFFF_0808, rd);
      check(rd, 32'h0);
      check({30'h0, sckOut, sdaOeN}, 32'h3);
   endtask

   task automatic t_write(input logic [7:0] c, input logic [7:0] v,
                          input logic ack);
      realtime t0;
      reg_wr(`HVIF_ADDR_DAT, {20'h0, 4'hF, v});
      reg_wr(`HVIF_ADDR_CMD, {24'h0, c});
      t0 = $realtime;
      // Issued while busy, so it must be dropped
      reg_wr(`HVIF_ADDR_CMD, 32'h0000_0001);
      reg_rd(`HVIF_ADDR_CMD, rd);
      check({31'h0, rd[0]}, 32'h1);
      wait_idle(t0);
      reg_rd(`HVIF_ADDR_CMD, rd);
      check(rd, {29'h0, ack, 2'h0});
      reg_rd(`HVIF_ADDR_DAT, rd);
      check(rd, {20'h0, c[3:0], v});
      check({24'h0, c[0] ? cfgSecond : cfgFirst}, {24'h0, v});
   endtask

   task automatic t_read(input logic [7:0] c, input logic [7:0] v,
                         input logic ack);
      realtime t0;
      reg_wr(`HVIF_ADDR_CMD, {24'h0, c});
      t0 = $realtime;
      wait_idle(t0);
      reg_rd(`HVIF_ADDR_CMD, rd);
      check(rd, {29'h0, ack, ack, 1'b0});
      reg_rd(`HVIF_ADDR_DAT, rd);
      check(rd, {20'h0, c[3:0], v});
   endtask

   task automatic t_bad(input logic [7:0] c);
      logic q;
      q = 1'b1;
      reg_wr(`HVIF_ADDR_CMD, {24'h0, c});
      repeat (24) begin
         @(posedge clk_sys);
         q = q & sckOut;
      end
      check({31'h0, q}, 32'h1);
      reg_rd(`HVIF_ADDR_CMD, rd);
      check({31'h0, rd[0]}, 32'h0);
   endtask

   initial begin
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (16) @(posedge clk_sys);
      t_reset();
      t_write(`HVIF_CODE_WR_CFG0, 8'hA6, 1'b1);
      t_write(`HVIF_CODE_WR_CFG1, 8'h5B, 1'b1);
      t_read(`HVIF_CODE_RD_CFG0, 8'hA6, 1'b1);
      t_read(`HVIF_CODE_RD_CFG1, 8'h5B, 1'b1);
      t_read(`HVIF_CODE_RD_STAT, 8'hA5, 1'b1);
      t_read(`HVIF_CODE_RD_MON, 8'h3C, 1'b1);
      t_bad(8'h04);
      t_bad(8'h0A);
      t_bad(8'hFF);
      @(posedge clk_sys);
      noAck <= 1'b1;
      t_write(`HVIF_CODE_WR_CFG0, 8'h81, 1'b0);
      t_read(`HVIF_CODE_RD_CFG0, 8'h81, 1'b0);
      give_verdict();
   end
endmodule

`default_nettype wire

// ===== test/hvif_far_model.sv
// Behavioural model of the register logic on the high-voltage die
`default_nettype none

module hvif_far_model #(
   parameter logic [7:0] StatVal = 8'h00,
   parameter logic [7:0] MonVal  = 8'h00
) (
   // Serial link pins
   input  wire logic       linkClk,
   input  wire logic       sckOut,
   input  wire logic       sdaOut,
   input  wire logic       sdaOeN,
   output logic            sdaIn,
   // Fault control and register view
   input  wire logic       noAck,
   output logic      [7:0] cfgFirst,
   output logic      [7:0] cfgSecond
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] rises = '0;
   logic [7:0] cmd = '0;
   logic [7:0] shIn = '0;
   logic [7:0] rdByte = '0;
   logic       drv = 1'b0;
   logic       drvVal = 1'b1;
   logic       sckLast = 1'b1;
   int         idle = 0;
   initial cfgFirst = '0;
   initial cfgSecond = '0;
   // Released line floats up through the pull-up
   assign sdaIn = (sdaOeN ? 1'b1 : sdaOut) & (drv ? drvVal : 1'b1);

   always @(posedge sckOut) begin
      if (rises < 8) cmd = {cmd[6:0], sdaIn};
      else if (cmd[3] && rises < 16) begin
         shIn = {shIn[6:0], sdaIn};
         if (rises == 15 && cmd == 8'h08) cfgFirst = shIn;
         if (rises == 15 && cmd == 8'h09) cfgSecond = shIn;
      end
      if (rises == 7) begin
         case (cmd)
            8'h00: rdByte = cfgFirst;
            8'h01: rdByte = cfgSecond;
            8'h02: rdByte = StatVal;
            default: rdByte = MonVal;
         endcase
      end
      rises = rises + 5'd1;
   end

   // Drive only after a fall, so the level holds across the next rise
   always @(negedge sckOut) begin
      drv = 1'b0;
      drvVal = 1'b0;
      if (cmd[3] && rises == 16) drv = !noAck;
      if (!cmd[3] && (rises == 8 || rises == 17)) drv = !noAck;
      if (!cmd[3] && rises >= 9 && rises <= 16) begin
         drv = 1'b1;
         drvVal = rdByte[5'd16 - rises];
      end
   end

   // Clock standing still means the frame is over
   always @(posedge linkClk) begin
      idle = (sckOut != sckLast) ? 0 : idle + 1;
      sckLast = sckOut;
      if (idle == 6) begin
         rises = '0;
         drv = 1'b0;
      end
   end
endmodule

`default_nettype wire
